/* File: verilog/ampc_pkg.sv */
// constants, register layouts and state codes of the converter mode control
package ampc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DATA_W = 14;
  localparam int PIPE_DEPTH = 12;
  localparam int WAKE_FULL_NS = 350000;
  localparam int DISCH_NS = 250000;
  localparam int STBY_WAKE_NS = 1000;
  localparam int RELOCK_NS = 1500;
  localparam int WIN_NS = 1000;
  localparam int SLOW_MHZ = 20;
  // least times, rounded up to whole cycles; window length and minimum strobe count rounded down
  localparam int WAKE_FULL_CYC =
    (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCH_CYC = (DISCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY_WAKE_CYC =
    (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELOCK_CYC = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_CYC = WIN_NS / CLK_PERIOD_NS;
  localparam int SLOW_MIN = SLOW_MHZ * WIN_NS / 1000;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WAKE_OFS = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  typedef enum logic [1:0] {
    FMT_OFFSET = 2'h0,
    FMT_TWOS = 2'h1,
    FMT_GRAY = 2'h2
  } ampc_fmt_t;
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_STANDBY = 2'h2
  } ampc_pwr_t;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_DOWN = 4'h2,
    ST_STANDBY = 4'h4,
    ST_WAKE = 4'h8
  } ampc_state_t;
  typedef struct packed {
    logic [26:0] rsvd;
    logic [1:0] pwr;
    logic stab;
    logic [1:0] fmt;
  } ampc_ctrl_t;
  typedef struct packed {
    logic [21:0] rsvd;
    logic [1:0] fmt;
    logic duty_regen;
    logic clk_slow;
    logic locked;
    logic valid;
    logic waking;
    logic standby;
    logic down;
    logic pin_mode;
  } ampc_status_t;
endpackage

/* File: verilog/ampc_stab_if.sv */
// signals between the mode control and the stabilizer lock monitor
interface ampc_stab_if;
  logic enable;
  logic strobe;
  logic locked;
  logic slow;
  logic active;
  modport ctrl (output enable, output strobe, input locked, input slow,
    input active);
  modport mon (input enable, input strobe, output locked, output slow,
    output active);
endinterface

/* File: verilog/ampc_stab_monitor.sv */
// duty cycle stabilizer lock, low-rate and relock bypass tracking
module ampc_stab_monitor
(
  input wire logic core_clk,
  input wire logic rst_n,
  ampc_stab_if.mon stab
);
  import ampc_pkg::*;

  logic [7:0] win_cnt;
  logic [7:0] strobe_cnt;
  logic [7:0] prev_cnt;
  logic [7:0] relock_cnt;
  logic seen;
  logic slow;

  wire win_end = win_cnt == 8'(WIN_CYC - 1);
  wire [7:0] cnt_total = strobe_cnt + {7'h00, stab.strobe};
  wire [7:0] rate_diff = (cnt_total > prev_cnt) ? cnt_total - prev_cnt
                                                : prev_cnt - cnt_total;
  // one strobe of jitter per window is not a rate change
  wire rate_jump = seen & (rate_diff > 8'h01);
  wire relock_busy = relock_cnt != 8'h00;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_cnt <= 8'h00;
      strobe_cnt <= 8'h00;
      prev_cnt <= 8'h00;
      seen <= 1'b0;
      slow <= 1'b1;
    end
    else if (win_end)
    begin
      win_cnt <= 8'h00;
      strobe_cnt <= 8'h00;
      prev_cnt <= cnt_total;
      seen <= stab.enable;
      slow <= cnt_total < 8'(SLOW_MIN);
    end
    else
    begin
      win_cnt <= win_cnt + 8'h01;
      strobe_cnt <= cnt_total;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      relock_cnt <= 8'(RELOCK_CYC);
    else if (!stab.enable || (win_end && rate_jump))
      relock_cnt <= 8'(RELOCK_CYC);
    else if (relock_busy)
      relock_cnt <= relock_cnt - 8'h01;
  end

  assign stab.slow = slow;
  assign stab.locked = !relock_busy & !slow & seen;
  // bypassed while relocking: timing follows the input clock's own duty
  assign stab.active = stab.enable & stab.locked;

  default clocking mcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_relock_bypass: assert property (relock_busy |-> !stab.active)
    else $error("stabilizer active while relocking");
  a_jump_reload: assert property (
    stab.enable && win_end && rate_jump |=> relock_cnt == 8'(RELOCK_CYC))
    else $error("rate change did not restart relock");
  a_slow_unlocked: assert property (slow |-> !stab.locked && !stab.active)
    else $error("stabilizer locked below minimum rate");
  c_relock_done: cover property ($fell(relock_busy) && stab.enable);
endmodule

/* File: verilog/ampc_adc_mode_power_control.sv */
// mode strap, serial mode, stabilizer, power-down and output control
module ampc_adc_mode_power_control
#(
  parameter int unsigned WAKE_FULL = ampc_pkg::WAKE_FULL_CYC,
  parameter int unsigned DISCH = ampc_pkg::DISCH_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic power_down_in,
  input wire logic serial_select_n,
  input wire logic serial_clock_format_strap,
  input wire logic serial_data_stabilizer_strap,
  input wire logic sample_strobe,
  input wire logic [ampc_pkg::DATA_W-1:0] sample_code,
  output logic [ampc_pkg::DATA_W-1:0] data_out,
  output logic [ampc_pkg::DATA_W-1:0] data_oe,
  output logic data_valid,
  output logic ref_powered,
  output logic duty_regen
);
  import ampc_pkg::*;

  ampc_stab_if stab ();
  ampc_ctrl_t ctrl;
  logic [15:0] wake_limit;
  ampc_state_t state;
  ampc_state_t next_state;
  logic [15:0] wake_cnt;
  logic [15:0] down_cnt;
  logic [3:0] fill_cnt;
  logic [DATA_W-1:0] pipe [PIPE_DEPTH-1];

  ampc_stab_monitor u_stab
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .stab(stab)
  );

  // register bus decode
  wire hit_ctrl = paddr == CTRL_OFS;
  wire hit_status = paddr == STATUS_OFS;
  wire hit_wake = paddr == WAKE_OFS;
  wire addr_ok = hit_ctrl | hit_status | hit_wake;
  wire apb_start = psel & penable & !pready;
  wire apb_done = psel & penable & pready;
  wire wr_ok = apb_done & pwrite & addr_ok;
  wire ampc_ctrl_t wr_ctrl = ampc_ctrl_t'(pwdata);

  // mode selection: pins in pin mode, registers otherwise; the power-down pin acts in both modes
  wire pin_mode = serial_select_n;
  wire ampc_fmt_t pin_fmt = serial_clock_format_strap ? FMT_TWOS
                                                      : FMT_OFFSET;
  // the unused fourth code falls back to offset binary
  wire ampc_fmt_t reg_fmt = (ctrl.fmt == FMT_TWOS) ? FMT_TWOS
                          : (ctrl.fmt == FMT_GRAY) ? FMT_GRAY
                          : FMT_OFFSET;
  wire ampc_fmt_t eff_fmt = pin_mode ? pin_fmt : reg_fmt;
  wire eff_stab = pin_mode ? serial_data_stabilizer_strap
                           : ctrl.stab;
  wire req_down = power_down_in
                | (!pin_mode & ctrl.pwr == PWR_DOWN);
  wire req_stby = !power_down_in & !pin_mode
                & ctrl.pwr == PWR_STANDBY;
  wire running = state == ST_ACTIVE || state == ST_WAKE;
  wire released = next_state == ST_ACTIVE || next_state == ST_WAKE;

  // wake time grows with down time, capped by the programmed limit
  wire [31:0] wake_scaled = (32'(down_cnt) * 32'(WAKE_FULL))
                          / 32'(DISCH);
  wire [15:0] wake_full_load = (wake_scaled > 32'(wake_limit))
                             ? wake_limit : wake_scaled[15:0];
  wire [15:0] wake_load = (state == ST_STANDBY) ? 16'(STBY_WAKE_CYC)
                                                : wake_full_load;

  // output coding, applied at the sampling end of the pipeline
  wire [DATA_W-1:0] code_twos = {~sample_code[DATA_W-1],
                                 sample_code[DATA_W-2:0]};
  wire [DATA_W-1:0] code_gray = sample_code ^ (sample_code >> 1);
  wire [DATA_W-1:0] code_fmt = (eff_fmt == FMT_TWOS) ? code_twos
                             : (eff_fmt == FMT_GRAY) ? code_gray
                             : sample_code;
  wire pipe_shift = sample_strobe & running;
  wire fill_done = fill_cnt == 4'(PIPE_DEPTH);

  wire ampc_status_t status = '{
    rsvd: '0,
    fmt: eff_fmt,
    duty_regen: duty_regen,
    clk_slow: stab.slow,
    locked: stab.locked,
    valid: data_valid,
    waking: state == ST_WAKE,
    standby: state == ST_STANDBY,
    down: state == ST_DOWN,
    pin_mode: pin_mode
  };
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl)
                     : hit_status ? 32'(status)
                     : hit_wake ? {16'h0000, wake_limit}
                     : 32'h0000_0000;

  assign stab.enable = eff_stab & running;
  assign stab.strobe = pipe_shift;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_start;
      prdata <= apb_start ? rd_mux : 32'h0000_0000;
      pslverr <= apb_start & !addr_ok;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= ampc_ctrl_t'(CTRL_RST);
      wake_limit <= 16'(WAKE_FULL);
    end
    else if (wr_ok && hit_ctrl)
    begin
      ctrl.fmt <= wr_ctrl.fmt;
      ctrl.stab <= wr_ctrl.stab;
      ctrl.pwr <= wr_ctrl.pwr;
    end
    else if (wr_ok && hit_wake)
      wake_limit <= pwdata[15:0];
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_ACTIVE:
        if (req_down)
          next_state = ST_DOWN;
        else if (req_stby)
          next_state = ST_STANDBY;
      ST_DOWN:
        if (!req_down)
          next_state = req_stby ? ST_STANDBY : ST_WAKE;
      ST_STANDBY:
        if (req_down)
          next_state = ST_DOWN;
        else if (!req_stby)
          next_state = ST_WAKE;
      ST_WAKE:
        if (req_down)
          next_state = ST_DOWN;
        else if (req_stby)
          next_state = ST_STANDBY;
        else if (wake_cnt == 16'h0000)
          next_state = ST_ACTIVE;
      default:
        next_state = ST_DOWN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // down time saturates once the reference capacitors are empty
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      down_cnt <= 16'h0000;
    else if (state == ST_DOWN && down_cnt < 16'(DISCH))
      down_cnt <= down_cnt + 16'h0001;
    else if (state == ST_ACTIVE)
      down_cnt <= 16'h0000;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_cnt <= 16'h0000;
    else if (state != ST_WAKE && next_state == ST_WAKE)
      wake_cnt <= wake_load;
    else if (state == ST_WAKE && wake_cnt != 16'h0000)
      wake_cnt <= wake_cnt - 16'h0001;
  end

  // sample pipeline: eleven stages plus the output register
  genvar gi;
  for (gi = 0; gi < PIPE_DEPTH - 1; gi++)
  begin : g_pipe
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        pipe[gi] <= '0;
      else if (pipe_shift)
        pipe[gi] <= (gi == 0) ? code_fmt : pipe[(gi == 0) ? 0 : gi - 1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      data_out <= '0;
    else if (pipe_shift)
      data_out <= pipe[PIPE_DEPTH-2];
  end

  // valid only once a full pipeline of fresh samples is out of wake-up
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fill_cnt <= 4'h0;
    else if (!running)
      fill_cnt <= 4'h0;
    else if (pipe_shift && !fill_done)
      fill_cnt <= fill_cnt + 4'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_oe <= '0;
      data_valid <= 1'b0;
      ref_powered <= 1'b0;
      duty_regen <= 1'b0;
    end
    else
    begin
      data_oe <= {DATA_W{released}};
      data_valid <= state == ST_ACTIVE && next_state == ST_ACTIVE
                  && fill_done;
      ref_powered <= next_state != ST_DOWN;
      duty_regen <= stab.active;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_pin_hold_down: assert property (
    power_down_in |=> state == ST_DOWN)
    else $error("power-down pin did not hold power-down");
  a_down_stays_down: assert property (
    state == ST_DOWN && req_down |=> state == ST_DOWN)
    else $error("left power-down while still requested");
  a_pin_release_wake: assert property (
    state == ST_DOWN && !power_down_in && !req_stby && !req_down
    |=> state == ST_WAKE)
    else $error("release of power-down did not start wake-up");
  a_down_hiz_out: assert property (
    state == ST_DOWN || state == ST_STANDBY |-> data_oe == '0)
    else $error("data drivers enabled while powered down");
  a_wake_no_valid: assert property (
    state == ST_WAKE |=> !data_valid)
    else $error("output valid during wake-up");
  a_valid_when_active: assert property (
    data_valid |-> state == ST_ACTIVE)
    else $error("output valid outside normal operation");
  a_wake_count_run: assert property (
    state == ST_WAKE && wake_cnt != 16'h0000 && !req_down && !req_stby
    |=> state == ST_WAKE && wake_cnt == $past(wake_cnt) - 16'h0001)
    else $error("wake-up ended early");
  // strap taken from the sampling cycle, the word was coded then
  a_pin_fmt_sel: assert property (
    pin_mode && pipe_shift |=> pipe[0] == ($past(serial_clock_format_strap)
      ? {~$past(sample_code[DATA_W-1]), $past(sample_code[DATA_W-2:0])}
      : $past(sample_code)))
    else $error("strap format not applied");
  a_pin_stab_sel: assert property (
    pin_mode && running |-> stab.enable == serial_data_stabilizer_strap)
    else $error("stabilizer strap not applied");
  a_regen_locked: assert property (
    duty_regen |-> $past(stab.locked) && $past(eff_stab))
    else $error("edge regeneration without lock");
  a_regen_off_disabled: assert property (
    !eff_stab |=> !duty_regen)
    else $error("edge regeneration while stabilizer disabled");
  a_gray_code: assert property (
    !pin_mode && reg_fmt == FMT_GRAY && pipe_shift
    |=> pipe[0] == ($past(sample_code) ^ ($past(sample_code) >> 1)))
    else $error("gray coding wrong");
  a_reg_twos: assert property (
    !pin_mode && reg_fmt == FMT_TWOS && pipe_shift
    |=> pipe[0] == {~$past(sample_code[DATA_W-1]),
      $past(sample_code[DATA_W-2:0])})
    else $error("twos complement coding wrong");
  a_standby_ref_on: assert property (
    state == ST_STANDBY |-> ref_powered)
    else $error("reference off in standby");
  a_down_ref_off: assert property (
    state == ST_DOWN |-> !ref_powered)
    else $error("reference on in full power-down");
  a_stby_fast_wake: assert property (
    state == ST_STANDBY && next_state == ST_WAKE
    |=> wake_cnt == 16'(STBY_WAKE_CYC))
    else $error("standby wake-up time not loaded");
  a_out_latency: assert property (
    pipe_shift |=> data_out == $past(pipe[PIPE_DEPTH-2]))
    else $error("output stage skipped");
  a_out_hold: assert property (
    !pipe_shift |=> data_out == $past(data_out))
    else $error("output word changed without a sample");

  c_full_wake: cover property (state == ST_WAKE ##1 state == ST_ACTIVE);
  c_standby_wake: cover property (state == ST_STANDBY ##1 state == ST_WAKE);
  c_first_valid: cover property ($rose(data_valid));
  c_regen_on: cover property ($rose(duty_regen));
endmodule

/* File: test/ampc_capture_model.sv */
// receiving logic model: resolves the data lines and keeps the last word
module ampc_capture_model
(
  input wire logic core_clk,
  input wire logic [ampc_pkg::DATA_W-1:0] data_out,
  input wire logic [ampc_pkg::DATA_W-1:0] data_oe,
  output logic [ampc_pkg::DATA_W-1:0] bus_word,
  output logic released
);
  import ampc_pkg::*;
  logic [DATA_W-1:0] last_word = '0;
  // a floating line shows the inverse of its last level, so it never
  // passes for held data
  assign bus_word = (data_oe & data_out)
                  | (~data_oe & ~last_word);
  assign released = (data_oe == '0);
  always @(posedge core_clk)
    last_word <= bus_word;
endmodule

/* File: test/adc_mode_power_control_test.sv */
// self-checking bench of the converter mode and power control
module adc_mode_power_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ampc_pkg::*;
  localparam int WF = 35;
  localparam int DC = 25;
  typedef struct {
    logic pin;
    logic strap;
    logic [1:0] fmt;
    logic [DATA_W-1:0] code;
    logic [DATA_W-1:0] exp;
  } ampc_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, er;
  logic [31:0] prdata, rd;
  logic power_down_in = 1'b0;
  logic serial_select_n = 1'b0;
  logic serial_clock_format_strap = 1'b0;
  logic serial_data_stabilizer_strap = 1'b1;
  logic sample_strobe = 1'b0;
  logic [DATA_W-1:0] sample_code = 14'h0000;
  logic [DATA_W-1:0] data_out, data_oe, bus_word;
  logic data_valid, ref_powered, duty_regen, released;
  int smode = 0;
  int failures = 0;
  int total_checks = 0;
  int n, nl;
  ampc_row_t rows [7] = '{
    '{1'b1, 1'b0, 2'h2, 14'h2000, 14'h2000},
    '{1'b1, 1'b1, 2'h0, 14'h2000, 14'h0000},
    '{1'b1, 1'b1, 2'h0, 14'h3FFF, 14'h1FFF},
    '{1'b0, 1'b1, 2'h0, 14'h1234, 14'h1234},
    '{1'b0, 1'b0, 2'h1, 14'h1234, 14'h3234},
    '{1'b0, 1'b0, 2'h2, 14'h1234, 14'h1B2E},
    '{1'b0, 1'b0, 2'h3, 14'h1234, 14'h1234}};

  ampc_adc_mode_power_control #(.WAKE_FULL(WF), .DISCH(DC))
    ampc_adc_mode_power_control_inst
  (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .power_down_in, .serial_select_n,
    .serial_clock_format_strap, .serial_data_stabilizer_strap,
    .sample_strobe, .sample_code, .data_out, .data_oe, .data_valid,
    .ref_powered, .duty_regen
  );
  ampc_capture_model ampc_capture_model_inst
  (
    .core_clk, .data_out, .data_oe, .bus_word, .released
  );

  always #20 core_clk = ~core_clk;
  // free-running sample stream: every cycle, or every other for a slow clock
  always @(posedge core_clk)
  begin
    if (smode != 0)
      sample_strobe <= (smode == 1) || !sample_strobe;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (k >= 50)
    begin
      failures++;
      conclude();
    end
  endtask
  task automatic rchk(input string s, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(s, e, rd & m);
  endtask
  task automatic wait_hi(input bit sel, output int c);
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while ((sel ? duty_regen : data_valid) !== 1'b1 && c < 2000);
    if (c >= 2000)
    begin
      failures++;
      conclude();
    end
  endtask
  task automatic strobes(input int c, input logic [DATA_W-1:0] b);
    for (int i = 0; i < c; i++)
    begin
      sample_strobe <= 1'b1;
      sample_code <= b + 14'(i);
      @(posedge core_clk);
    end
    sample_strobe <= 1'b0;
    @(posedge core_clk);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rchk("ctrl", CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST);
    smode = 1;
    foreach (rows[i])
    begin
      serial_select_n <= rows[i].pin;
      serial_clock_format_strap <= rows[i].strap;
      sample_code <= rows[i].code;
      apb(1'b1, CTRL_OFS, {29'h0, 1'b1, rows[i].fmt});
      repeat (14) @(posedge core_clk);
      chk("word", 32'(rows[i].exp), 32'(data_out));
      chk("bus", 32'(rows[i].exp), 32'(bus_word));
      chk("valid", 32'h1, 32'(data_valid));
    end
    done("formats");
    smode = 0;
    @(posedge core_clk);
    strobes(11, 14'h0100);
    chk("early", 32'h1234, 32'(data_out));
    strobes(1, 14'h010B);
    chk("late", 32'h0100, 32'(data_out));
    done("latency");
    smode = 1;
    sample_code <= 14'h1234;
    power_down_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("oe", 32'h0, 32'(data_oe));
    chk("released", 32'h1, 32'(released));
    chk("ref", 32'h0, 32'(ref_powered));
    chk("valid", 32'h0, 32'(data_valid));
    repeat (30) @(posedge core_clk);
    power_down_in <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("oe", 32'h3FFF, 32'(data_oe));
    chk("valid", 32'h0, 32'(data_valid));
    wait_hi(1'b0, nl);
    chk("long wake", 32'h1, 32'(nl >= WF));
    power_down_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    power_down_in <= 1'b0;
    repeat (2) @(posedge core_clk);
    wait_hi(1'b0, n);
    chk("short wake", 32'h1, 32'(n + 20 < nl));
    done("power pin");
    apb(1'b1, CTRL_OFS, 32'h0000_0014);
    @(posedge core_clk);
    chk("ref", 32'h1, 32'(ref_powered));
    chk("oe", 32'h0, 32'(data_oe));
    rchk("status", STATUS_OFS, 32'h0000_0006, 32'h0000_0004);
    apb(1'b1, CTRL_OFS, 32'h0000_0004);
    wait_hi(1'b0, n);
    chk("stby wake", 32'h1, 32'(n >= STBY_WAKE_CYC && n + 5 < nl));
    apb(1'b1, CTRL_OFS, 32'h0000_000C);
    @(posedge core_clk);
    chk("ref", 32'h0, 32'(ref_powered));
    rchk("status", STATUS_OFS, 32'h0000_0006, 32'h0000_0002);
    apb(1'b1, CTRL_OFS, 32'h0000_0004);
    wait_hi(1'b0, n);
    done("power register");
    wait_hi(1'b1, n);
    chk("regen", 32'h1, 32'(duty_regen));
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("regen", 32'h0, 32'(duty_regen));
    serial_select_n <= 1'b1;
    serial_data_stabilizer_strap <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("regen", 32'h0, 32'(duty_regen));
    serial_data_stabilizer_strap <= 1'b1;
    wait_hi(1'b1, n);
    chk("relock", 32'h1, 32'(n >= RELOCK_CYC - 1));
    smode = 2;
    repeat (80) @(posedge core_clk);
    chk("regen", 32'h0, 32'(duty_regen));
    rchk("slow", STATUS_OFS, 32'h0000_0040, 32'h0000_0040);
    smode = 1;
    wait_hi(1'b1, n);
    chk("relock", 32'h1, 32'(n >= RELOCK_CYC - 1));
    done("stabilizer");
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("err", 32'h1, 32'(er));
    chk("rd", 32'h0, rd);
    apb(1'b1, WAKE_OFS, 32'h0000_0023);
    rchk("wake", WAKE_OFS, 32'hFFFF_FFFF, 32'h0000_0023);
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    chk("err", 32'h0, 32'(er));
    rchk("pin", STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    done("registers");
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("oe", 32'h0, 32'(data_oe));
    chk("valid", 32'h0, 32'(data_valid));
    rst_n <= 1'b1;
    @(posedge core_clk);
    rchk("ctrl", CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST);
    done("reset");
    conclude();
  end
endmodule
